//--- hdl/spme_pkg.sv
// package: constants and carrier types for serial programming mode entry
`default_nettype none
package spme_pkg;
   localparam int          KEY_BITS      = 32;
   // entry key value is arbitrary
   localparam logic [31:0] KEY_DEFAULT   = 32'h3a5c_96e1;
   localparam int          SYNC_STAGES   = 2;
   localparam logic        LVE_RESET_VAL = 1'b1;

   // pin levels seen on the programming link
   typedef struct packed {
      logic sclk;
      logic sdat;
      logic mclr_n;
      logic hv;
   } spme_pins_t;

   // idle levels: master clear released high, no high voltage
   localparam spme_pins_t  PINS_IDLE     = '{sclk: 1'b0, sdat: 1'b0, mclr_n: 1'b1, hv: 1'b0};

   // bidirectional data pin driver, oe low while driving
   typedef struct packed {
      logic dat_o;
      logic dat_oe_n;
   } spme_dat_drv_t;

   typedef enum logic [1:0] {
      SPME_RUN,
      SPME_KEY,
      SPME_HV_SESSION,
      SPME_LV_SESSION
   } spme_mode_t;
endpackage : spme_pkg
`default_nettype wire

//--- hdl/spme_sync.sv
// module: two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
`default_nettype none
module spme_sync
   import spme_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire spme_pins_t pins_async,
   output var spme_pins_t  pins_sync
);
   typedef struct packed {
      spme_pins_t s1;
      spme_pins_t s2;
   } spme_sync_state_t;

   spme_sync_state_t st_reg;
   spme_sync_state_t st_next;

   always_comb begin
      st_next    = st_reg;
      st_next.s1 = pins_async;
      st_next.s2 = st_reg.s1;
   end

   // reset level: master clear released high, no high voltage
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '{s1: PINS_IDLE, s2: PINS_IDLE};
      end else begin
         st_reg <= st_next;
      end
   end

   assign pins_sync = st_reg.s2;
endmodule : spme_sync
`default_nettype wire

//--- hdl/spme_entry.sv
// module: program/verify mode entry logic for the two-wire programming link
`timescale 1ns/1ns
`default_nettype none
module spme_entry
   import spme_pkg::*;
#(
   parameter logic [31:0] ENTRY_KEY = KEY_DEFAULT
)
(
   input  wire logic   clk_sys,
   input  wire logic   sys_rst,
   input  wire logic   prog_serial_clock,
   input  wire logic   prog_serial_data_i,
   output logic        prog_serial_data_o,
   output logic        prog_serial_data_oe_n,
   input  wire logic   master_clear_vpp_pin,
   input  wire logic   master_clear_hv,
   input  wire logic   mclr_reset_cfg_en,
   input  wire logic   resp_bit,
   input  wire logic   resp_drive,
   input  wire logic   lve_clear_req,
   output logic        low_voltage_entry_enable,
   output logic        prog_mode,
   output logic        prog_mode_hv,
   output logic        prog_clk_rise,
   output logic        prog_data_bit,
   output logic        mclr_reset_en,
   output logic        core_reset
);
   spme_pins_t pins_async;
   spme_pins_t pins;

   assign pins_async = '{sclk: prog_serial_clock, sdat: prog_serial_data_i,
                         mclr_n: master_clear_vpp_pin, hv: master_clear_hv};

   spme_sync u_sync (
      .clk_sys    (clk_sys),
      .sys_rst    (sys_rst),
      .pins_async (pins_async),
      .pins_sync  (pins)
   );

   typedef struct packed {
      spme_mode_t    mode;
      logic          sclk_d;
      logic [31:0]   key_sr;
      logic [5:0]    key_cnt;
      logic          lve;
      logic          hv_armed;
      logic          rise;
      logic          dbit;
      spme_dat_drv_t drv;
   } spme_state_t;

   spme_state_t st_reg;
   spme_state_t st_next;
   logic        sclk_rise;

   assign sclk_rise = pins.sclk && !st_reg.sclk_d;

   function automatic logic [31:0] spme_key_shift(input logic [31:0] sr, input logic b);
      return {sr[30:0], b};
   endfunction : spme_key_shift

   function automatic logic spme_in_session(input spme_mode_t m);
      return (m == SPME_HV_SESSION) || (m == SPME_LV_SESSION);
   endfunction : spme_in_session

   always_comb begin
      st_next        = st_reg;
      st_next.sclk_d = pins.sclk;
      st_next.rise   = 1'b0;
      st_next.drv    = '{dat_o: 1'b0, dat_oe_n: 1'b1};
      // clock and data must be low before high voltage arrives
      st_next.hv_armed = !pins.hv && !pins.sclk && !pins.sdat;
      case (st_reg.mode)
         SPME_RUN: begin
            st_next.key_cnt = 6'h00;
            if (pins.hv && st_reg.hv_armed) begin
               st_next.mode = SPME_HV_SESSION;
            end else if (!pins.mclr_n && st_reg.lve) begin
               st_next.mode = SPME_KEY;
            end
         end
         SPME_KEY: begin
            if (pins.mclr_n || !st_reg.lve) begin
               st_next.mode = SPME_RUN;
            end else if (sclk_rise) begin
               st_next.key_sr  = spme_key_shift(st_reg.key_sr, pins.sdat);
               st_next.key_cnt = st_reg.key_cnt + 6'h01;
               if (st_reg.key_cnt == 6'(KEY_BITS - 1)) begin
                  // a mismatch drops to run mode, which restarts key capture while master clear stays low
                  if (spme_key_shift(st_reg.key_sr, pins.sdat) == ENTRY_KEY) begin
                     st_next.mode = SPME_LV_SESSION;
                  end else begin
                     st_next.mode = SPME_RUN;
                  end
               end
            end
         end
         SPME_HV_SESSION: begin
            if (!pins.hv) begin
               st_next.mode = SPME_RUN;
            end else if (lve_clear_req) begin
               st_next.lve = 1'b0;
            end
         end
         SPME_LV_SESSION: begin
            if (pins.mclr_n) begin
               st_next.mode = SPME_RUN;
            end
         end
         default: begin
            st_next.mode = SPME_RUN;
         end
      endcase
      if (spme_in_session(st_reg.mode)) begin
         st_next.rise = sclk_rise;
         st_next.dbit = pins.sdat;
         st_next.drv  = '{dat_o: resp_bit, dat_oe_n: !resp_drive};
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '{mode: SPME_RUN, sclk_d: 1'b0, key_sr: 32'h0000_0000,
                     key_cnt: 6'h00, lve: LVE_RESET_VAL, hv_armed: 1'b0,
                     rise: 1'b0, dbit: 1'b0, drv: 2'h1};
      end else begin
         st_reg <= st_next;
      end
   end

   assign prog_serial_data_o       = st_reg.drv.dat_o;
   assign prog_serial_data_oe_n    = st_reg.drv.dat_oe_n;
   assign low_voltage_entry_enable = st_reg.lve;
   assign prog_mode    = spme_in_session(st_reg.mode);
   assign prog_mode_hv = (st_reg.mode == SPME_HV_SESSION);
   assign prog_clk_rise = st_reg.rise;
   assign prog_data_bit = st_reg.dbit;
   assign mclr_reset_en = st_reg.lve || mclr_reset_cfg_en;
   assign core_reset    = prog_mode || (mclr_reset_en && !pins.mclr_n);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_lv_key_done;
      st_reg.mode == SPME_KEY && !pins.mclr_n && sclk_rise
         && st_reg.key_cnt == 6'(KEY_BITS - 1);
   endsequence

   sequence s_session_edge;
      prog_mode && sclk_rise;
   endsequence

   a_lv_needs_enable: assert property ((st_reg.mode == SPME_RUN && !st_reg.lve)
      |=> st_reg.mode != SPME_KEY) else $error("key capture started while disabled");

   a_lv_session_drop: assert property ((st_reg.mode == SPME_LV_SESSION && pins.mclr_n)
      |=> st_reg.mode == SPME_RUN) else $error("low-voltage session outlived master clear");

   a_mclr_forced_on: assert property (st_reg.lve |-> mclr_reset_en)
      else $error("master clear reset disabled while enable bit set");

   a_mclr_reset_core: assert property ((st_reg.lve && !pins.mclr_n) |-> core_reset)
      else $error("core not reset by master clear with enable bit set");

   a_lve_clear_hv_only: assert property ($fell(st_reg.lve)
      |-> $past(st_reg.mode) == SPME_HV_SESSION) else $error("enable bit cleared outside hv");

   a_lve_clear_hv: assert property ((st_reg.mode == SPME_HV_SESSION && pins.hv && lve_clear_req)
      |=> !st_reg.lve) else $error("enable bit clear refused in hv session");

   a_key_wrong_run: assert property ((s_lv_key_done
      ##0 (spme_key_shift(st_reg.key_sr, pins.sdat) != ENTRY_KEY)) |=> st_reg.mode == SPME_RUN)
      else $error("bad key entered session");

   a_key_right_lv: assert property ((s_lv_key_done
      ##0 (spme_key_shift(st_reg.key_sr, pins.sdat) == ENTRY_KEY)) |=> prog_mode)
      else $error("good key refused");

   a_key_abort: assert property ((st_reg.mode == SPME_KEY && pins.mclr_n)
      |=> st_reg.mode == SPME_RUN) else $error("key capture survived master clear release");

   a_key_cnt_clear: assert property (st_reg.mode == SPME_RUN |=> st_reg.key_cnt == 6'h00)
      else $error("key bit count not cleared");

   a_hv_entry: assert property ((st_reg.mode == SPME_RUN && pins.hv && st_reg.hv_armed)
      |=> prog_mode_hv) else $error("high-voltage entry missed");

   a_hv_needs_arm: assert property ((st_reg.mode == SPME_RUN && !st_reg.hv_armed)
      |=> !prog_mode_hv) else $error("hv entry without clock and data low");

   a_hv_session_drop: assert property ((st_reg.mode == SPME_HV_SESSION && !pins.hv)
      |=> !prog_mode) else $error("hv session outlived high voltage");

   a_dat_quiet_run: assert property (!prog_mode |=> prog_serial_data_oe_n)
      else $error("data pin driven outside session");

   a_dat_drive_session: assert property ((prog_mode && resp_drive)
      |=> (!prog_serial_data_oe_n && prog_serial_data_o == $past(resp_bit)))
      else $error("data pin not driven in session");

   a_clk_rise_fwd: assert property (s_session_edge |=> prog_clk_rise)
      else $error("session clock edge lost");

   a_data_bit_edge: assert property (s_session_edge |=> prog_data_bit == $past(pins.sdat))
      else $error("session data bit not captured");

   a_rise_single: assert property (prog_clk_rise |=> !prog_clk_rise)
      else $error("clock edge pulse longer than one cycle");

   a_core_in_session: assert property (prog_mode |-> core_reset)
      else $error("core running during session");
endmodule : spme_entry
`default_nettype wire

//--- sim/spme_prog_model.sv
// programmer model: drives the link pins for both entry modes
`timescale 1ns/1ns
`default_nettype none
module spme_prog_model
   import spme_pkg::*;
(
   input  wire logic clk_sys,
   output var spme_pins_t pins
);
   initial pins = '{sclk: 1'b0, sdat: 1'b0, mclr_n: 1'b1, hv: 1'b0};
   task automatic hold(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : hold
   task automatic bit_out(input logic b);
      pins.sdat = b;
      hold(4);
      pins.sclk = 1'b1;
      hold(4);
      pins.sclk = 1'b0;
   endtask : bit_out
   task automatic hv_on();
      pins.sclk = 1'b0;
      pins.sdat = 1'b0;
      hold(4);
      pins.hv = 1'b1;
      hold(8);
   endtask : hv_on
   task automatic hv_bad();
      pins.sclk = 1'b1;
      hold(4);
      pins.hv = 1'b1;
      hold(4);
      pins.sclk = 1'b0;
      hold(8);
   endtask : hv_bad
   task automatic lv_key(input logic [31:0] key);
      pins.mclr_n = 1'b0;
      hold(4);
      for (int i = 31; i >= 0; i--) bit_out(key[i]);
      pins.sdat = ~key[0];
      hold(8);
   endtask : lv_key
   task automatic quit();
      pins.hv = 1'b0;
      pins.mclr_n = 1'b1;
      pins.sdat = ~pins.sdat;
      hold(8);
   endtask : quit
endmodule : spme_prog_model
`default_nettype wire

//--- sim/tb_top.sv
// testbench: entry, refusal and session checks of the mode entry logic
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import spme_pkg::*;
;
   typedef struct {logic [31:0] key; logic exp;} spme_row_t;
   spme_row_t  rows [3] = '{'{KEY_DEFAULT, 1'b1}, '{KEY_DEFAULT ^ 32'h1, 1'b0},
                           '{KEY_DEFAULT ^ 32'h8000_0000, 1'b0}};
   spme_pins_t pins;
   logic       clk_sys, sys_rst, cfg_en, resp_bit, resp_drive, clr_req;
   logic       data_o, oe_n, lve, pm, pm_hv, data_bit, rst_en, clk_rise, core_rst;
   int         error_cnt = 0;
   int         rise_cnt = 0;
   int         compares = 0;
   spme_prog_model spme_prog_model_inst (.clk_sys(clk_sys), .pins(pins));
   spme_entry spme_entry_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .prog_serial_clock(pins.sclk),
      .prog_serial_data_i(oe_n ? pins.sdat : data_o), .prog_serial_data_o(data_o),
      .prog_serial_data_oe_n(oe_n), .master_clear_vpp_pin(pins.mclr_n | pins.hv),
      .master_clear_hv(pins.hv), .mclr_reset_cfg_en(cfg_en), .resp_bit(resp_bit),
      .resp_drive(resp_drive), .lve_clear_req(clr_req), .low_voltage_entry_enable(lve),
      .prog_mode(pm), .prog_mode_hv(pm_hv), .prog_clk_rise(clk_rise), .prog_data_bit(data_bit),
      .mclr_reset_en(rst_en), .core_reset(core_rst));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // counts one-cycle clock edge pulses forwarded in session
   always @(negedge clk_sys) begin
      if (clk_rise === 1'b1) begin
         rise_cnt++;
      end
   end
   task automatic chk(input string nm, input logic e, input logic s);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %b seen %b", nm, e, s);
      end
   endtask : chk
   task automatic summarize();
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize
   initial begin
      {sys_rst, cfg_en, resp_bit, resp_drive, clr_req} = 5'h10;
      repeat (12) @(negedge clk_sys);
      sys_rst = 1'b0;
      chk("lve", 1'b1, lve);
      chk("oe_n", 1'b1, oe_n);
      chk("rst_en", 1'b1, rst_en);
      foreach (rows[i]) begin
         spme_prog_model_inst.lv_key(rows[i].key);
         chk("lv_mode", rows[i].exp, pm);
         spme_prog_model_inst.quit();
      end
      // low-voltage session: data turn-around, bit capture, refused clear
      spme_prog_model_inst.lv_key(KEY_DEFAULT);
      spme_prog_model_inst.bit_out(1'b1);
      chk("data_bit", 1'b1, data_bit);
      spme_prog_model_inst.bit_out(1'b0);
      chk("data_bit", 1'b0, data_bit);
      chk("clk_rise_cnt", 1'b1, rise_cnt == 2);
      {resp_drive, resp_bit, clr_req} = 3'h7;
      spme_prog_model_inst.hold(4);
      chk("oe_n", 1'b0, oe_n);
      chk("data_o", 1'b1, data_o);
      chk("lve", 1'b1, lve);
      chk("core_rst", 1'b1, core_rst);
      {resp_drive, resp_bit, clr_req} = 3'h0;
      spme_prog_model_inst.quit();
      chk("lv_mode", 1'b0, pm);
      // high-voltage session clears the enable bit
      spme_prog_model_inst.hv_on();
      chk("hv_mode", 1'b1, pm);
      chk("hv_flag", 1'b1, pm_hv);
      clr_req = 1'b1;
      spme_prog_model_inst.hold(4);
      chk("lve", 1'b0, lve);
      clr_req = 1'b0;
      spme_prog_model_inst.quit();
      chk("rst_en", 1'b0, rst_en);
      spme_prog_model_inst.lv_key(KEY_DEFAULT);
      chk("lv_mode", 1'b0, pm);
      spme_prog_model_inst.quit();
      cfg_en = 1'b1;
      spme_prog_model_inst.hold(1);
      chk("rst_en", 1'b1, rst_en);
      cfg_en = 1'b0;
      // high voltage with the clock high must be refused
      spme_prog_model_inst.hv_bad();
      chk("hv_mode", 1'b0, pm);
      spme_prog_model_inst.quit();
      // mid-run reset restores the erased enable bit
      sys_rst = 1'b1;
      spme_prog_model_inst.hold(2);
      sys_rst = 1'b0;
      chk("lve", 1'b1, lve);
      spme_prog_model_inst.lv_key(KEY_DEFAULT);
      chk("lv_mode", 1'b1, pm);
      spme_prog_model_inst.quit();
      chk("lv_mode", 1'b0, pm);
      chk("core_rst", 1'b0, core_rst);
      summarize();
   end
endmodule : tb_top
`default_nettype wire
